// ---- smc_pkg.sv ----
`default_nettype none
package smc_pkg;
  // Upper control byte layout, bits 23..13
  localparam int OMC_WIDTH         = 24;
  localparam int EXT_EN_BIT        = 20;
  localparam int WRAP_FLAG_BIT     = 19;
  localparam int OVF_FLAG_BIT      = 18;
  localparam int UNF_FLAG_BIT      = 17;
  localparam int SPACE_SEL_BIT     = 16;
  localparam int TRACE_EN_BIT      = 15;
  localparam int ATTR_PRIO_DIS_BIT = 14;
  localparam int ASYNC_ARB_BIT     = 13;
  localparam int CTRL_LSB          = 13;
  localparam int CTRL_MSB          = 23;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [2:0]  STACK_ERR_LEVEL = 3'h3;
  localparam int PTR_WIDTH         = 5;
  localparam int ATTR_COUNT        = 4;
  localparam int ADDR_WIDTH        = 18;

  typedef struct packed {
    logic                  push_req;
    logic                  pull_req;
    logic                  wrap_begin;
    logic [PTR_WIDTH-1:0]  stack_pointer;
    logic [PTR_WIDTH-1:0]  stack_size;
  } smc_stack_evt_t;

  typedef struct packed {
    logic                  we;
    logic [OMC_WIDTH-1:0]  wdata;
  } smc_reg_wr_t;
endpackage
`default_nettype wire

// ---- smc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Extension enable bit gates stack extension
// - Reset clears bits twenty down to thirteen
// - Wrap flag set when spill begins
// - Flags sticky until reset or write
// - Overflow on push when pointer equals size
// - Overflow rise raises level three exception
// - Underflow on pull when pointer zero
// - Underflow rise raises level three exception
// - Pointer underflow bit counts in extension
// - Space select chooses X or Y
// - Trace drives internal addresses outward
// - Attributes prioritised, three highest, one-hot
// - Priority disabled allows several attributes
// - Async mode synchronises grant and busy
// - Reserved bits zero after reset
module smc_top (
  input  wire logic                               clk,             // Core clock
  input  wire logic                               sys_rst,         // Async reset, high
  input  wire logic                               clk_en,          // Freezes state when low
  input  wire smc_pkg::smc_reg_wr_t               reg_wr,          // Control move write
  input  wire smc_pkg::smc_stack_evt_t            stack_evt,       // Stack hardware events
  input  wire logic [smc_pkg::ADDR_WIDTH-1:0]     int_addr,        // Internal access address
  input  wire logic                               int_access,      // Internal access strobe
  input  wire logic [smc_pkg::ADDR_WIDTH-1:0]     ext_addr,        // External access address
  input  wire logic [smc_pkg::ATTR_COUNT-1:0]     attr_raw,        // Raw attribute matches
  input  wire logic                               bus_grant_in,    // Bus grant pin
  input  wire logic                               bus_busy,        // Bus busy pin
  output logic [smc_pkg::OMC_WIDTH-1:0]           reg_rdata,       // Register read value
  output logic                                    extension_on,    // Stack extension active
  output logic                                    ext_space_y,     // Extension in Y space
  output logic                                    ptr_uf_counts,   // Pointer underflow bit counts
  output logic                                    stack_err_exc,   // Stack error pulse
  output logic [2:0]                              stack_err_level, // Exception priority
  output logic [smc_pkg::ADDR_WIDTH-1:0]          bus_addr,        // External address lines
  output logic [smc_pkg::ATTR_COUNT-1:0]          address_attribute_outputs, // Attribute pins
  output logic                                    grant_seen,      // Accepted grant
  output logic                                    busy_seen        // Accepted busy
);
  import smc_pkg::*;

  logic [CTRL_MSB:CTRL_LSB] ctrl_q, ctrl_d;
  logic [1:0] grant_sync_q, busy_sync_q;
  logic grant_pin_q, busy_pin_q;

  wire ext_en   = ctrl_q[EXT_EN_BIT];
  wire ovf_evt  = ext_en && stack_evt.push_req && (stack_evt.stack_pointer == stack_evt.stack_size);
  wire unf_evt  = ext_en && stack_evt.pull_req && (stack_evt.stack_pointer == '0);
  wire wrap_evt = ext_en && stack_evt.wrap_begin;
  // Any zero-to-one step raises it, from the stack hardware or from a write
  wire ovf_rise = ctrl_d[OVF_FLAG_BIT] && !ctrl_q[OVF_FLAG_BIT];
  wire unf_rise = ctrl_d[UNF_FLAG_BIT] && !ctrl_q[UNF_FLAG_BIT];

  // Write loads bits; flags stay otherwise, hardware set wins over write
  wire [CTRL_MSB:CTRL_LSB] wr_val = reg_wr.we ? reg_wr.wdata[CTRL_MSB:CTRL_LSB] : ctrl_q;
  wire [CTRL_MSB:CTRL_LSB] set_mask = ({(CTRL_MSB-CTRL_LSB+1){1'b0}}
                                      | ((CTRL_MSB-CTRL_LSB+1)'(wrap_evt) << (WRAP_FLAG_BIT-CTRL_LSB))
                                      | ((CTRL_MSB-CTRL_LSB+1)'(ovf_evt)  << (OVF_FLAG_BIT-CTRL_LSB))
                                      | ((CTRL_MSB-CTRL_LSB+1)'(unf_evt)  << (UNF_FLAG_BIT-CTRL_LSB)));
  // Reserved bits never store a one
  assign ctrl_d = {3'h0, wr_val[EXT_EN_BIT:CTRL_LSB] | set_mask[EXT_EN_BIT:CTRL_LSB]};

  // Fixed priority: highest index wins, one hot
  function automatic logic [ATTR_COUNT-1:0] attr_prio(input logic [ATTR_COUNT-1:0] raw);
    logic [ATTR_COUNT-1:0] res;
    logic                  taken;
    res   = '0;
    taken = 1'b0;
    for (int i = ATTR_COUNT-1; i >= 0; i--) begin
      if (raw[i] && !taken) begin
        res[i] = 1'b1;
        taken  = 1'b1;
      end
    end
    return res;
  endfunction

  wire [ATTR_COUNT-1:0] attr_d = ctrl_q[ATTR_PRIO_DIS_BIT] ? attr_raw : attr_prio(attr_raw);
  wire [ADDR_WIDTH-1:0] addr_d = (ctrl_q[TRACE_EN_BIT] && int_access) ? int_addr : ext_addr;
  // Sync path adds two cycles; the arbiter's non-overlap gap covers it
  wire grant_d = ctrl_q[ASYNC_ARB_BIT] ? grant_sync_q[1] : grant_pin_q;
  wire busy_d  = ctrl_q[ASYNC_ARB_BIT] ? busy_sync_q[1]  : busy_pin_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Pins cross two stages before use in async mode, three when async mode is off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      grant_sync_q <= 2'h0;
      busy_sync_q  <= 2'h0;
      grant_pin_q  <= 1'b0;
      busy_pin_q   <= 1'b0;
    end else if (clk_en) begin
      grant_sync_q <= {grant_sync_q[0], bus_grant_in};
      busy_sync_q  <= {busy_sync_q[0], bus_busy};
      grant_pin_q  <= grant_sync_q[1];
      busy_pin_q   <= busy_sync_q[1];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata                 <= 24'h000000;
      extension_on              <= 1'b0;
      ext_space_y               <= 1'b0;
      ptr_uf_counts             <= 1'b0;
      stack_err_exc             <= 1'b0;
      stack_err_level           <= 3'h0;
      bus_addr                  <= '0;
      address_attribute_outputs <= '0;
      grant_seen                <= 1'b0;
      busy_seen                 <= 1'b0;
    end else if (clk_en) begin
      reg_rdata                 <= {ctrl_d, 13'h0000};
      extension_on              <= ctrl_d[EXT_EN_BIT];
      ext_space_y               <= ctrl_d[SPACE_SEL_BIT];
      ptr_uf_counts             <= ctrl_d[EXT_EN_BIT];
      stack_err_exc             <= ovf_rise || unf_rise;
      stack_err_level           <= STACK_ERR_LEVEL;
      bus_addr                  <= addr_d;
      address_attribute_outputs <= attr_d;
      grant_seen                <= grant_d;
      busy_seen                 <= busy_d;
    end
  end
endmodule
`default_nettype wire

// ---- smc_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module smc_asserts (
  input wire logic                     clk,                      // Core clock
  input wire logic                     sys_rst,                  // Reset
  input wire logic                     clk_en,                   // Enable
  input wire smc_pkg::smc_reg_wr_t     reg_wr,                   // Write
  input wire smc_pkg::smc_stack_evt_t  stack_evt,                // Events
  input wire logic [3:0]               attr_raw,                 // Raw
  input wire logic [23:0]              reg_rdata,                // Read
  input wire logic                     extension_on,             // Active
  input wire logic                     stack_err_exc,            // Error
  input wire logic [3:0]               address_attribute_outputs // Pins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic evt_any = stack_evt.push_req | stack_evt.pull_req | stack_evt.wrap_begin;
  wire logic ptr_eq = stack_evt.stack_pointer == stack_evt.stack_size;
  property p_wr; clk_en && reg_wr.we && !evt_any |=> reg_rdata == {3'h0, $past(reg_wr.wdata[20:13]), 13'h0}; endproperty
  a_wr: assert property (p_wr) else $error("write wrong");
  property p_ovf; clk_en && extension_on && stack_evt.push_req && ptr_eq |=> reg_rdata[18]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");
  property p_unf; clk_en && extension_on && stack_evt.pull_req && stack_evt.stack_pointer == 5'h0 |=> reg_rdata[17]; endproperty
  a_unf: assert property (p_unf) else $error("underflow missed");
  property p_wrp; clk_en && extension_on && stack_evt.wrap_begin |=> reg_rdata[19]; endproperty
  a_wrp: assert property (p_wrp) else $error("wrap missed");
  property p_stk; !reg_wr.we |=> (reg_rdata[19:17] & $past(reg_rdata[19:17])) == $past(reg_rdata[19:17]); endproperty
  a_stk: assert property (p_stk) else $error("flag lost");
  property p_exc; stack_err_exc == ($rose(reg_rdata[18]) || $rose(reg_rdata[17])); endproperty
  a_exc: assert property (p_exc) else $error("exception wrong");
  property p_pri; clk_en && !reg_rdata[14] |=> $onehot0(address_attribute_outputs)
    && (address_attribute_outputs & $past(attr_raw)) == address_attribute_outputs
    && {1'b0, $past(attr_raw)} < {address_attribute_outputs, 1'b0} + {4'h0, $past(attr_raw) == 4'h0}; endproperty
  a_pri: assert property (p_pri) else $error("priority wrong");
  property p_all; clk_en && reg_rdata[14] |=> address_attribute_outputs == $past(attr_raw); endproperty
  a_all: assert property (p_all) else $error("attributes wrong");
  c_ovf: cover property (stack_err_exc && reg_rdata[18]);
  c_unf: cover property (stack_err_exc && reg_rdata[17]);
  c_wrp: cover property ($rose(reg_rdata[19]));
endmodule
bind smc_top smc_asserts smc_asserts_i (.clk, .sys_rst, .clk_en, .reg_wr, .stack_evt, .attr_raw, .reg_rdata,
  .extension_on, .stack_err_exc, .address_attribute_outputs);
`default_nettype wire

// ---- smc_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module smc_core_model (
  input wire logic                 clk, // Core clock
  output var smc_pkg::smc_stack_evt_t evt // Stack events
);
  initial evt = '0;
  // Caller enters on a rising edge; event lasts one cycle
  task automatic op(input logic [2:0] k, input logic [4:0] ptr, input logic [4:0] size);
    evt <= {k, ptr, size};
    @(posedge clk);
    evt <= '0;
  endtask
endmodule
`default_nettype wire

// ---- stack_ext_and_bus_mode_control_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module stack_ext_and_bus_mode_control_tb_top;
  import smc_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, int_access = 0, bus_grant_in = 0, bus_busy = 0;
  logic [17:0] int_addr = '0, ext_addr = '0, bus_addr;
  logic [3:0] attr_raw = '0, address_attribute_outputs;
  logic [23:0] reg_rdata;
  logic [2:0] stack_err_level;
  logic extension_on, ext_space_y, ptr_uf_counts, stack_err_exc, grant_seen, busy_seen;
  smc_reg_wr_t reg_wr = '0;
  smc_stack_evt_t stack_evt;
  int errors = 0, checks_done = 0;
  always #2 clk = ~clk;
  smc_core_model smc_core_model_i (.clk, .evt(stack_evt));
  smc_top smc_top_i (.clk, .sys_rst, .clk_en, .reg_wr, .stack_evt, .int_addr, .int_access, .ext_addr, .attr_raw,
    .bus_grant_in, .bus_busy, .reg_rdata, .extension_on, .ext_space_y, .ptr_uf_counts, .stack_err_exc,
    .stack_err_level, .bus_addr, .address_attribute_outputs, .grant_seen, .busy_seen);
  task automatic wr(input logic [23:0] v);
    @(posedge clk);
    reg_wr <= {1'b1, v};
    @(posedge clk);
    reg_wr.we <= 1'b0;
    #1;
  endtask
  task automatic ev(input logic [2:0] k, input logic [4:0] ptr, input logic [4:0] size);
    @(posedge clk);
    smc_core_model_i.op(k, ptr, size);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset", 24'h0, reg_rdata)
    `CHK("level", 3'h3, stack_err_level)
    wr(24'hffffff);
    `CHK("ones", 24'h1fe000, reg_rdata)
    `CHK("modes", 3'h7, {extension_on, ext_space_y, ptr_uf_counts})
    @(posedge clk);
    attr_raw <= 4'hb;
    int_addr <= 18'h2a5a5;
    int_access <= 1'b1;
    bus_grant_in <= 1'b1;
    bus_busy <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("attr", 4'hb, address_attribute_outputs)
    `CHK("trace", 18'h2a5a5, bus_addr)
    `CHK("early", 1'b0, grant_seen)
    repeat (2) @(posedge clk);
    #1;
    `CHK("sync", 2'h3, {grant_seen, busy_seen})
    $display("mode test done");
    wr(24'h100000);
    `CHK("clear", 24'h100000, reg_rdata)
    @(posedge clk);
    #1;
    `CHK("prio", 4'h8, address_attribute_outputs)
    `CHK("untrace", 18'h0, bus_addr)
    @(posedge clk);
    bus_grant_in <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("drop", 1'b0, grant_seen)
    @(posedge clk);
    bus_grant_in <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("slow", 1'b0, grant_seen)
    @(posedge clk);
    #1;
    `CHK("grant", 1'b1, grant_seen)
    ev(3'h4, 5'h9, 5'h9);
    `CHK("ovf", 2'h3, {reg_rdata[18], stack_err_exc})
    ev(3'h2, 5'h0, 5'h9);
    `CHK("unf", 2'h3, {reg_rdata[17], stack_err_exc})
    ev(3'h1, 5'h2, 5'h9);
    ev(3'h4, 5'h3, 5'h9);
    `CHK("sticky", 25'h1e0000, {stack_err_exc, reg_rdata})
    @(posedge clk);
    reg_wr <= {1'b1, 24'h100000};
    smc_core_model_i.op(3'h4, 5'h4, 5'h4);
    reg_wr.we <= 1'b0;
    #1;
    `CHK("race", 24'h140000, reg_rdata)
    wr(24'h0);
    ev(3'h4, 5'h9, 5'h9);
    `CHK("off", 24'h0, reg_rdata)
    $display("flag test done");
    report_and_stop;
  end
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
